// ===== wrc_top.sv
/*
 * Watchdog timer with key-protected enable and the device reset sequencer.
 * Assumes the core issues clear-watchdog and halt as one-cycle pulses and that
 * the slow RC clock, reset pin and low-voltage detector are asynchronous.
 */
`timescale 1ns/1ps
module wrc_top
   import wrc_pkg::*;
#(
   parameter int unsigned RSTD_CYCLES = RSTD_CYC
)
(
   input  wire logic              clk_sys_i,
   input  wire logic              nrst_i,
   input  wire logic              low_speed_rc_clock_clk_i,
   input  wire logic              ext_reset_pin_n_i,
   input  wire logic              low_voltage_reset_i,
   input  wire logic              clear_watchdog_instruction_i,
   input  wire logic              halt_instruction_i,
   input  wire logic              wake_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic      [DATA_W-1:0] rdata_o,
   output logic                   core_reset_o,
   output logic                   core_stall_o,
   output logic                   pc_sp_reset_o,
   output logic                   timeout_flag_o,
   output logic                   powerdown_flag_o,
   output logic      [DATA_W-1:0] port_data_o,
   output logic      [DATA_W-1:0] port_dir_o
);

   // ---------------------------------------------------------------
   // Input synchronisers and tick generator
   // ---------------------------------------------------------------
   logic low_speed_rc_clock_lvl;
   logic ext_pin_lvl;
   logic lvr_lvl;

   wrc_sync #(.RST_VAL(1'b0)) u_sync_low_speed_rc_clock
   (
      .clk_sys_i (clk_sys_i),
      .nrst_i    (nrst_i),
      .async_i   (low_speed_rc_clock_clk_i),
      .level_o   (low_speed_rc_clock_lvl)
   );

   wrc_sync #(.RST_VAL(1'b1)) u_sync_pin
   (
      .clk_sys_i (clk_sys_i),
      .nrst_i    (nrst_i),
      .async_i   (ext_reset_pin_n_i),
      .level_o   (ext_pin_lvl)
   );

   wrc_sync #(.RST_VAL(1'b0)) u_sync_lvr
   (
      .clk_sys_i (clk_sys_i),
      .nrst_i    (nrst_i),
      .async_i   (low_voltage_reset_i),
      .level_o   (lvr_lvl)
   );

   wrc_tick_if tk ();

   wrc_tick u_tick
   (
      .clk_sys_i  (clk_sys_i),
      .nrst_i     (nrst_i),
      .low_speed_rc_clock_lvl_i (low_speed_rc_clock_lvl),
      .tk         (tk)
   );

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   wrc_state_t          state_q;
   wrc_state_t          state_d;
   logic [2:0]          period_q;
   logic [7:0]          ctrl_q;
   logic [DATA_W-1:0]   pdata_q;
   logic [DATA_W-1:0]   pdir_q;
   logic [CNT_W-1:0]    cnt_q;
   logic [RSTD_W-1:0]   rstd_q;
   logic [4:0]          sst_q;
   logic [1:0]          noise_q;
   logic                sleep_q;
   logic                sleep_d;
   logic                to_q;
   logic                pdf_q;
   logic [DATA_W-1:0]   rdata_q;
   logic                core_reset_q;
   logic                core_stall_q;
   logic                pc_sp_q;

   // ---------------------------------------------------------------
   // Decoding
   // ---------------------------------------------------------------
   wire        wr_period   = wr_i && (addr_i == OFF_PERIOD);
   wire        wr_ctrl     = wr_i && (addr_i == OFF_CTRL);
   wire        wr_pdata    = wr_i && (addr_i == OFF_PDATA);
   wire        wr_pdir     = wr_i && (addr_i == OFF_PDIR);
   wire [5:0]  key_wr      = wdata_i[5:0];
   wire [5:0]  key_now     = ctrl_q[5:0];
   wire        running     = (state_q == ST_RUN);
   wire        enabled     = (key_now == KEY_ENABLE);
   wire        soft_bad    = wr_ctrl && !wrc_key_valid(key_wr);
   wire        key_upset   = !wrc_key_valid(key_now);
   wire        noise_rst   = key_upset && tk.low_speed_rc_clock_tick && (noise_q == NOISE_TICKS - 2'h1);
   wire        full_rst    = !ext_pin_lvl || lvr_lvl;
   wire        clr_ok      = clear_watchdog_instruction_i && enabled && running && !sleep_q;
   wire        halt_ok     = halt_instruction_i && running && !sleep_q;
   wire        at_limit    = (cnt_q == wrc_last_count(period_q));
   wire        overflow    = running && enabled && tk.tick && at_limit;
   wire        wdt_norm    = overflow && !sleep_q;
   wire        wdt_wake    = overflow && sleep_q;
   wire        other_wake  = sleep_q && wake_i && running;
   wire        dev_rst     = wdt_norm || soft_bad || noise_rst;
   wire        reinit      = full_rst || dev_rst;
   wire        clr_cnt     = full_rst || soft_bad || noise_rst || clr_ok || halt_ok
                             || overflow || !enabled || !running;
   wire        rstd_done   = (rstd_q == (RSTD_W)'(RSTD_CYCLES - 1));
   wire        sst_done    = (sst_q == SST_CYC - 5'h01);

   wire [DATA_W-1:0] status_rd = {5'h00, enabled, pdf_q, to_q};
   wire [DATA_W-1:0] rd_mux    = (addr_i == OFF_PERIOD) ? {5'h00, period_q} :
                                 (addr_i == OFF_CTRL)   ? ctrl_q :
                                 (addr_i == OFF_STATUS) ? status_rd :
                                 (addr_i == OFF_PDATA)  ? pdata_q :
                                 (addr_i == OFF_PDIR)   ? pdir_q : 8'h00;

   assign tk.clk_sel = ctrl_q[7:6];
   assign tk.sleep   = sleep_q;

   // ---------------------------------------------------------------
   // Reset sequencer
   // ---------------------------------------------------------------
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         ST_DELAY:
         begin
            if (full_rst)
               state_d = ST_HOLD;
            else if (rstd_done)
               state_d = ST_RUN;
         end
         ST_HOLD:
         begin
            if (!full_rst)
               state_d = ST_DELAY;
         end
         ST_RUN:
         begin
            if (full_rst)
               state_d = ST_HOLD;
            else if (dev_rst)
               state_d = ST_DELAY;
            else if (wdt_wake || other_wake)
               state_d = ST_SST;
         end
         ST_SST:
         begin
            if (full_rst)
               state_d = ST_HOLD;
            else if (sst_done)
               state_d = ST_RUN;
         end
      endcase
   end

   always_comb
   begin
      sleep_d = sleep_q;
      if (halt_ok)
         sleep_d = 1'b1;
      if (state_d != ST_RUN)
         sleep_d = 1'b0;
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         state_q <= ST_DELAY;
      else
         state_q <= state_d;
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         rstd_q <= '0;
      else
         rstd_q <= (state_q == ST_DELAY && !rstd_done) ? rstd_q + (RSTD_W)'(1) : '0;
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         sst_q <= 5'h00;
      else
         sst_q <= (state_q == ST_SST) ? sst_q + 5'h01 : 5'h00;
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         sleep_q <= 1'b0;
      else
         sleep_q <= sleep_d;
   end

   // ---------------------------------------------------------------
   // Watchdog counter and key upset filter
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         cnt_q <= '0;
      else if (clr_cnt)
         cnt_q <= '0;
      else if (tk.tick)
         cnt_q <= cnt_q + (CNT_W)'(1);
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         noise_q <= 2'h0;
      else if (!key_upset || noise_rst)
         noise_q <= 2'h0;
      else if (tk.low_speed_rc_clock_tick)
         noise_q <= noise_q + 2'h1;
   end

   // ---------------------------------------------------------------
   // Software registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         period_q <= PERIOD_RST;
         ctrl_q   <= CTRL_RST;
      end
      else if (reinit)
      begin
         period_q <= PERIOD_RST;
         ctrl_q   <= CTRL_RST;
      end
      else
      begin
         if (wr_period)
            period_q <= wdata_i[2:0];
         if (wr_ctrl)
            ctrl_q <= wdata_i;
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         pdata_q <= PORT_RST;
         pdir_q  <= PORT_RST;
      end
      else if (reinit)
      begin
         pdata_q <= PORT_RST;
         pdir_q  <= PORT_RST;
      end
      else
      begin
         if (wr_pdata)
            pdata_q <= wdata_i;
         if (wr_pdir)
            pdir_q <= wdata_i;
      end
   end

   // ---------------------------------------------------------------
   // Reset cause flags
   // ---------------------------------------------------------------
   // Pin and low-voltage resets leave both flags as they were. A set in the
   // same cycle as a clear wins.
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         to_q  <= 1'b0;
         pdf_q <= 1'b0;
      end
      else
      begin
         if (overflow)
            to_q <= 1'b1;
         else if (halt_ok)
            to_q <= 1'b0;
         if (halt_ok)
            pdf_q <= 1'b1;
         else if (clr_ok)
            pdf_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         rdata_q <= 8'h00;
      else
         rdata_q <= rd_i ? rd_mux : 8'h00;
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         core_reset_q <= 1'b1;
         core_stall_q <= 1'b0;
         pc_sp_q      <= 1'b0;
      end
      else
      begin
         core_reset_q <= (state_d == ST_DELAY) || (state_d == ST_HOLD);
         core_stall_q <= (state_d == ST_SST) || sleep_d;
         pc_sp_q      <= wdt_wake;
      end
   end

   assign rdata_o          = rdata_q;
   assign core_reset_o     = core_reset_q;
   assign core_stall_o     = core_stall_q;
   assign pc_sp_reset_o    = pc_sp_q;
   assign timeout_flag_o   = to_q;
   assign powerdown_flag_o = pdf_q;
   assign port_data_o      = pdata_q;
   assign port_dir_o       = pdir_q;

endmodule : wrc_top

// ===== wrc_pkg.sv
/*
 * Constants, types and shared decoding for the watchdog and reset control block.
 * Assumes a single 125 MHz system clock and an 8-bit register port.
 */
package wrc_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam int unsigned ADDR_W      = 8;
   localparam int unsigned DATA_W      = 8;
   localparam logic [7:0]  OFF_PERIOD  = 8'h00;
   localparam logic [7:0]  OFF_CTRL    = 8'h01;
   localparam logic [7:0]  OFF_STATUS  = 8'h02;
   localparam logic [7:0]  OFF_PDATA   = 8'h03;
   localparam logic [7:0]  OFF_PDIR    = 8'h04;

   // ---------------------------------------------------------------
   // Fields and reset values
   // ---------------------------------------------------------------
   localparam logic [2:0]  PERIOD_RST  = 3'h7;
   localparam logic [7:0]  CTRL_RST    = 8'h00;
   localparam logic [7:0]  PORT_RST    = 8'hFF;
   localparam logic [5:0]  KEY_ENABLE  = 6'h00;
   localparam logic [5:0]  KEY_DISABLE = 6'h2D;
   localparam logic [1:0]  CLS_LOW_SPEED_RC_CLOCK    = 2'h0;
   localparam logic [1:0]  CLS_DIV4    = 2'h1;
   localparam int unsigned STS_TO      = 0;
   localparam int unsigned STS_PDF     = 1;
   localparam int unsigned STS_EN      = 2;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CNT_W       = 16;
   localparam int unsigned PERIOD_BASE = 8;
   localparam logic [1:0]  DIV4_LAST   = 2'h3;
   localparam logic [1:0]  NOISE_TICKS = 2'h2;
   localparam logic [4:0]  SST_CYC     = 5'h10;
   localparam int unsigned RESET_DELAY_TIME_MS    = 50;
   localparam int unsigned CLK_KHZ     = 125000;
   localparam int unsigned RSTD_CYC    = RESET_DELAY_TIME_MS * CLK_KHZ;
   localparam int unsigned RSTD_W      = 23;

   typedef enum logic [1:0] {ST_DELAY, ST_HOLD, ST_RUN, ST_SST} wrc_state_t;

   function automatic logic wrc_key_valid(input logic [5:0] key);
      return (key == KEY_ENABLE) || (key == KEY_DISABLE);
   endfunction : wrc_key_valid

   function automatic logic [CNT_W-1:0] wrc_last_count(input logic [2:0] sel);
      logic [CNT_W:0] lim;
      lim = (CNT_W+1)'(1) << (PERIOD_BASE + 32'(sel));
      return lim[CNT_W-1:0] - (CNT_W)'(1);
   endfunction : wrc_last_count

endpackage : wrc_pkg

// ===== wrc_tick_if.sv
/*
 * Signals between the watchdog core and its tick generator.
 * Assumes both ends run on the system clock.
 */
`timescale 1ns/1ps
interface wrc_tick_if;
   logic [1:0] clk_sel;
   logic       sleep;
   logic       low_speed_rc_clock_tick;
   logic       tick;

   modport ctl (output clk_sel, output sleep, input low_speed_rc_clock_tick, input tick);
   modport gen (input clk_sel, input sleep, output low_speed_rc_clock_tick, output tick);
endinterface : wrc_tick_if

// ===== wrc_sync.sv
/*
 * Three-stage synchroniser with agreement filter for inputs from other domains.
 * Assumes the input may change at any time relative to the system clock.
 */
`timescale 1ns/1ps
module wrc_sync
#(
   parameter logic RST_VAL = 1'b0
)
(
   input  wire logic clk_sys_i,
   input  wire logic nrst_i,
   input  wire logic async_i,
   output logic      level_o
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic lvl_q;

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         s1_q  <= RST_VAL;
         s2_q  <= RST_VAL;
         s3_q  <= RST_VAL;
         lvl_q <= RST_VAL;
      end
      else
      begin
         s1_q <= async_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q)
            lvl_q <= s3_q;
      end
   end

   assign level_o = lvl_q;
endmodule : wrc_sync

// ===== wrc_tick.sv
/*
 * Watchdog tick generator: slow clock edges, system clock and system clock over four.
 * Assumes the slow clock level arrives already synchronised.
 */
`timescale 1ns/1ps
module wrc_tick
   import wrc_pkg::*;
(
   input  wire logic clk_sys_i,
   input  wire logic nrst_i,
   input  wire logic low_speed_rc_clock_lvl_i,
   wrc_tick_if.gen   tk
);
   logic       low_speed_rc_clock_prev_q;
   logic [1:0] div_q;
   logic       tick_q;
   logic       low_speed_rc_clock_tick_q;
   logic       low_speed_rc_clock_edge;
   logic       div_pulse;
   logic       tick_d;

   assign low_speed_rc_clock_edge = low_speed_rc_clock_lvl_i && !low_speed_rc_clock_prev_q;
   assign div_pulse = (div_q == DIV4_LAST);
   // The system clock halts in sleep, so its derived ticks are gated off.
   assign tick_d    = (tk.clk_sel == CLS_LOW_SPEED_RC_CLOCK) ? low_speed_rc_clock_edge :
                      (tk.clk_sel == CLS_DIV4) ? (div_pulse && !tk.sleep) : !tk.sleep;

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         low_speed_rc_clock_prev_q <= 1'b0;
         div_q       <= 2'h0;
         tick_q      <= 1'b0;
         low_speed_rc_clock_tick_q <= 1'b0;
      end
      else
      begin
         low_speed_rc_clock_prev_q <= low_speed_rc_clock_lvl_i;
         div_q       <= tk.sleep ? div_q : div_q + 2'h1;
         tick_q      <= tick_d;
         low_speed_rc_clock_tick_q <= low_speed_rc_clock_edge;
      end
   end

   assign tk.tick      = tick_q;
   assign tk.low_speed_rc_clock_tick = low_speed_rc_clock_tick_q;
endmodule : wrc_tick

// ===== wrc_top_chk.sv
/*
 * Concurrent checks on the ports of the watchdog and reset control block.
 * Assumes one system clock and the register port timing of the block.
 */
`timescale 1ns/1ps
module wrc_top_chk
   import wrc_pkg::*;
#(
   parameter int unsigned RSTD_CYCLES = RSTD_CYC
)
(
   input  wire logic              clk_sys_i,
   input  wire logic              nrst_i,
   input  wire logic              ext_reset_pin_n_i,
   input  wire logic              low_voltage_reset_i,
   input  wire logic              halt_instruction_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   input  wire logic [DATA_W-1:0] rdata_o,
   input  wire logic              core_reset_o,
   input  wire logic              core_stall_o,
   input  wire logic              pc_sp_reset_o,
   input  wire logic              timeout_flag_o,
   input  wire logic              powerdown_flag_o,
   input  wire logic [DATA_W-1:0] port_data_o
);
   // -----------------------------------------------------------
   // Length of the reset hold once every reset source is quiet
   // -----------------------------------------------------------
   logic [31:0] hold_q;
   always_ff @(posedge clk_sys_i or negedge nrst_i)
      if (!nrst_i)
         hold_q <= 32'h0;
      else if (core_reset_o && ext_reset_pin_n_i && !low_voltage_reset_i)
         hold_q <= hold_q + 32'h1;
      else
         hold_q <= 32'h0;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);

   chk_read_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data not zero outside a read answer");
   chk_bad_key_reset: assert property (wr_i && addr_i == OFF_CTRL && wdata_i[5:0] != KEY_ENABLE
      && wdata_i[5:0] != KEY_DISABLE |=> core_reset_o) else $error("bad key write did not reset");
   chk_pin_reset: assert property (!ext_reset_pin_n_i [*6] |-> core_reset_o)
      else $error("reset pin low but core not held");
   chk_lvr_reset: assert property (low_voltage_reset_i [*6] |-> core_reset_o)
      else $error("low voltage but core not held");
   chk_halt_sleep: assert property (halt_instruction_i && !core_reset_o && !core_stall_o
      |=> powerdown_flag_o && core_stall_o) else $error("halt did not enter sleep");
   chk_pdf_cause: assert property ($rose(powerdown_flag_o) |-> $past(halt_instruction_i))
      else $error("powerdown flag rose without halt");
   chk_wake_pulse: assert property (pc_sp_reset_o |-> core_stall_o && !core_reset_o ##1 !pc_sp_reset_o)
      else $error("pc and sp reset pulse malformed");
   chk_wake_flag: assert property ($rose(pc_sp_reset_o) |-> ##[0:1] timeout_flag_o)
      else $error("sleep wake without timeout flag");
   chk_startup_len: assert property ($fell(pc_sp_reset_o) |-> core_stall_o [*8] ##1 core_stall_o [*6]
      ##[1:4] !core_stall_o) else $error("start-up stall length wrong");
   chk_timeout_cause: assert property ($rose(timeout_flag_o) |-> ##[0:1] (core_reset_o || pc_sp_reset_o))
      else $error("timeout flag without reset or wake");
   chk_reset_delay: assert property ($fell(core_reset_o) |-> hold_q >= RSTD_CYCLES - 1
      && hold_q <= RSTD_CYCLES + 8) else $error("reset delay length wrong");
   chk_port_init: assert property ($rose(core_reset_o) |=> port_data_o == PORT_RST)
      else $error("port data not reinitialised by reset");
endmodule : wrc_top_chk

bind wrc_top wrc_top_chk #(.RSTD_CYCLES(RSTD_CYCLES)) u_wrc_top_chk (
   .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ext_reset_pin_n_i(ext_reset_pin_n_i),
   .low_voltage_reset_i(low_voltage_reset_i), .halt_instruction_i(halt_instruction_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .core_reset_o(core_reset_o), .core_stall_o(core_stall_o), .pc_sp_reset_o(pc_sp_reset_o),
   .timeout_flag_o(timeout_flag_o), .powerdown_flag_o(powerdown_flag_o), .port_data_o(port_data_o));

// ===== test_wrc_top.sv
/*
 * Self-checking bench for the watchdog and reset control block.
 * Assumes a shortened reset delay and a fast stand-in for the slow RC clock.
 */
`timescale 1ns/1ps
module test_wrc_top
   import wrc_pkg::*;
();
   localparam int RSTD = 20;
   localparam int LP   = 12;
   logic       clk_sys_i, nrst_i, pin_n, low_voltage_reset, clr, halt, wake, wr_i, rd_i;
   logic       low_speed_rc_clock_clk_i = 1'b0;
   logic [7:0] addr_i, wdata_i, rdata_o, port_data_o, port_dir_o, v;
   logic       core_reset_o, core_stall_o, pc_sp_reset_o, timeout_flag_o, powerdown_flag_o;
   logic       rd_pend = 1'b0;
   logic [7:0] exp_q[$];
   int         error_cnt = 0;
   int         cmp_count = 0;
   int         cyc = 0;
   int         n, i, e;

   wrc_top #(.RSTD_CYCLES(RSTD)) u_wrc_top (
      .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .low_speed_rc_clock_clk_i(low_speed_rc_clock_clk_i), .ext_reset_pin_n_i(pin_n),
      .low_voltage_reset_i(low_voltage_reset), .clear_watchdog_instruction_i(clr), .halt_instruction_i(halt),
      .wake_i(wake), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .core_reset_o(core_reset_o), .core_stall_o(core_stall_o), .pc_sp_reset_o(pc_sp_reset_o),
      .timeout_flag_o(timeout_flag_o), .powerdown_flag_o(powerdown_flag_o),
      .port_data_o(port_data_o), .port_dir_o(port_dir_o));

   // -----------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : test_done

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      exp_q.push_back(x);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask : rd

   // Pulses clear (0), halt (1) or wake (2) for one cycle.
   task automatic pulse(input int s);
      if (s == 0)
         clr <= 1'b1;
      else if (s == 1)
         halt <= 1'b1;
      else
         wake <= 1'b1;
      @(posedge clk_sys_i);
      {clr, halt, wake} <= 3'h0;
      @(posedge clk_sys_i);
   endtask : pulse

   function automatic logic sig(input int s);
      return (s == 0) ? core_reset_o : (s == 1) ? core_stall_o : pc_sp_reset_o;
   endfunction : sig

   task automatic wait_sig(input int s, input logic lvl, input int lim, output int cnt);
      cnt = 0;
      while (sig(s) !== lvl && cnt < lim)
      begin
         @(posedge clk_sys_i);
         cnt++;
      end
      if (sig(s) !== lvl)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t: wait limit reached", $time);
      end
   endtask : wait_sig

   // -----------------------------------------------------------
   // Clock, slow clock stand-in, watchdog on the run, read monitor
   // -----------------------------------------------------------
   initial
   begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end

   always @(posedge clk_sys_i)
   begin
      cyc <= cyc + 1;
      rd_pend <= rd_i;
      if (cyc % (LP / 2) == 0)
         low_speed_rc_clock_clk_i <= ~low_speed_rc_clock_clk_i;
      if (cyc == 30000)
      begin
         error_cnt++;
         test_done();
      end
   end

   always @(negedge clk_sys_i)
      if (rd_pend === 1'b1)
         check(rdata_o, exp_q.pop_front());

   // -----------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------
   initial
   begin
      {nrst_i, clr, halt, wake, low_voltage_reset, wr_i, rd_i} = 7'h00;
      pin_n = 1'b1;
      addr_i = 8'h00;
      wdata_i = 8'h00;
      void'($urandom(79973));
      repeat (12) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      @(posedge clk_sys_i);
      check(8'({core_reset_o, timeout_flag_o, powerdown_flag_o}), 8'h04);
      check(port_data_o, PORT_RST);
      check(port_dir_o, PORT_RST);
      wait_sig(0, 1'b0, RSTD + 40, n);
      check(8'(n >= RSTD - 2 && n <= RSTD + 4), 8'h01);
      rd(OFF_PERIOD, 8'h07);
      rd(OFF_CTRL, CTRL_RST);
      rd(OFF_PDATA, PORT_RST);
      rd(OFF_PDIR, PORT_RST);
      wr(OFF_STATUS, 8'hFF);
      rd(OFF_STATUS, 8'h04);
      for (i = 0; i < 4; i++)
      begin
         v = 8'($urandom);
         wr(OFF_PDATA, v);
         wr(OFF_PDIR, ~v);
         wr(OFF_PERIOD, v);
         wr(8'h05, v);
         rd(OFF_PDATA, v);
         rd(OFF_PDIR, ~v);
         rd(OFF_PERIOD, {5'h00, v[2:0]});
         rd(8'h05, 8'h00);
      end
      $display("test 1 reset values and registers done");
      wr(OFF_CTRL, {2'h2, KEY_DISABLE});
      rd(OFF_CTRL, {2'h2, KEY_DISABLE});
      rd(OFF_STATUS, 8'h00);
      wr(OFF_PERIOD, 8'h00);
      pulse(0);
      repeat (400) @(posedge clk_sys_i);
      check(8'(core_reset_o), 8'h00);
      wr(OFF_CTRL, {2'h2, KEY_ENABLE});
      rd(OFF_STATUS, 8'h04);
      pulse(0);
      repeat (200) @(posedge clk_sys_i);
      pulse(0);
      repeat (200) @(posedge clk_sys_i);
      check(8'(core_reset_o), 8'h00);
      $display("test 2 enable key and clearing done");
      for (i = 0; i < 4; i++)
      begin
         e = (i == 0) ? 256 * LP : (i == 1) ? 1024 : (i == 2) ? 512 : 256;
         wr(OFF_PERIOD, (i == 2) ? 8'h01 : 8'h00);
         wr(OFF_CTRL, {2'(i), KEY_ENABLE});
         pulse(0);
         wait_sig(0, 1'b1, e + 100, n);
         check(8'(n + 2 >= e - ((i == 0) ? 2 * LP : 4) && n + 2 <= e + ((i == 0) ? 2 * LP : 4)), 8'h01);
         wait_sig(0, 1'b0, RSTD + 40, n);
         rd(OFF_STATUS, 8'h05);
         rd(OFF_PERIOD, 8'h07);
      end
      $display("test 3 overflow per clock source done");
      for (i = 0; i < 2; i++)
      begin
         wr(OFF_PDATA, 8'h5A);
         wr(OFF_PDIR, 8'h3C);
         if (i == 0)
            pin_n <= 1'b0;
         else
            low_voltage_reset <= 1'b1;
         repeat (10) @(posedge clk_sys_i);
         check(8'(core_reset_o), 8'h01);
         pin_n <= 1'b1;
         low_voltage_reset <= 1'b0;
         wait_sig(0, 1'b0, RSTD + 40, n);
         check(8'(n >= RSTD - 1 && n <= RSTD + 10), 8'h01);
         rd(OFF_STATUS, 8'h05);
         rd(OFF_PDATA, PORT_RST);
         check(port_dir_o, PORT_RST);
      end
      $display("test 4 pin and low voltage reset done");
      v = 8'($urandom);
      if (v[5:0] == KEY_ENABLE || v[5:0] == KEY_DISABLE)
         v = 8'h15;
      wr(OFF_PERIOD, 8'h03);
      wr(OFF_CTRL, v);
      check(8'(core_reset_o), 8'h01);
      wait_sig(0, 1'b0, RSTD + 40, n);
      rd(OFF_PERIOD, 8'h07);
      rd(OFF_CTRL, CTRL_RST);
      $display("test 5 invalid key done");
      wr(OFF_CTRL, {2'h2, KEY_ENABLE});
      wr(OFF_PERIOD, 8'h00);
      pulse(1);
      check(8'({powerdown_flag_o, timeout_flag_o}), 8'h02);
      repeat (600) @(posedge clk_sys_i);
      check(8'({core_reset_o, core_stall_o}), 8'h01);
      pulse(2);
      wait_sig(1, 1'b0, 60, n);
      check(8'(n >= 12 && n <= 18), 8'h01);
      pulse(0);
      check(8'(powerdown_flag_o), 8'h00);
      wr(OFF_CTRL, {2'h0, KEY_ENABLE});
      pulse(1);
      wait_sig(2, 1'b1, 300 * LP, n);
      check(8'(n + 2 >= 254 * LP && n + 2 <= 258 * LP), 8'h01);
      check(8'({core_reset_o, timeout_flag_o}), 8'h01);
      wait_sig(1, 1'b0, 60, n);
      check(8'(n >= 12 && n <= 18), 8'h01);
      rd(OFF_STATUS, 8'h07);
      $display("test 6 sleep and wake done");
      test_done();
   end
endmodule : test_wrc_top
